// ---- verilog/eeprom_map.svh ----
// Constants of the three-wire EEPROM: opcodes, field sizes, timing counts
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// ================================================================
// Timing and job queue depth
`define CLK_FREQ_MHZ     100
`define WP_TIME_US       3000
`define JOB_FIFO_DEPTH   8

// ================================================================
// Opcodes following the start bit
`define OP_SPECIAL       2'b00
`define OP_WRITE         2'b01
`define OP_READ          2'b10
`define OP_ERASE         2'b11

// ================================================================
// Two leading address bits of the special opcode
`define SUB_DISABLE      2'b00
`define SUB_WRITE_ALL    2'b01
`define SUB_ERASE_ALL    2'b10
`define SUB_ENABLE       2'b11

// ================================================================
// Field sizes and array shape
`define CMD_LAST_X8      5'h08
`define CMD_LAST_X16     5'h07
`define DATA_LAST_X8     5'h07
`define DATA_LAST_X16    5'h0F
`define MEM_WORDS        64
`define ERASED_WORD      16'hFFFF

`endif

// ---- verilog/eeprom_pkg.sv ----
// Types shared by the EEPROM decoder and its job queue
package eeprom_pkg;

  // ================================================================
  // Decoder states
  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'b000,
    ST_CMD     = 3'b001,
    ST_DATA    = 3'b010,
    ST_READOUT = 3'b011,
    ST_DONE    = 3'b100
  } dec_state_e;

  // ================================================================
  // Programming jobs handed to the self-timed engine
  typedef enum logic [1:0]
  {
    JOB_ERASE     = 2'b00,
    JOB_WRITE     = 2'b01,
    JOB_ERASE_ALL = 2'b10,
    JOB_WRITE_ALL = 2'b11
  } job_kind_e;

  typedef struct packed
  {
    job_kind_e   kind;
    logic        byteMode;
    logic [6:0]  addr;
    logic [15:0] data;
  } prog_job_s;

endpackage

// ---- verilog/stream_if.sv ----
// Valid/ready word stream between the decoder and the job queue
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- verilog/job_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module job_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  stream_if.snk     fillSide,
  stream_if.src     drainSide
);
  localparam int AW = $clog2(DEPTH);

  // ================================================================
  // Elaboration checks
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_depth_chk
    $error("job_fifo: DEPTH must be a power of two of at least 2");
  end
  if (WIDTH < 1)
  begin : g_width_chk
    $error("job_fifo: WIDTH must be positive");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      rdPtr_r;
  wire              empty = (wrPtr_r == rdPtr_r);
  wire              full  = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  wire              push  = fillSide.valid && !full;
  wire              pop   = drainSide.ready && !empty;

  // Extra pointer bit tells full from empty without a counter
  assign fillSide.ready  = !full;
  assign drainSide.valid = !empty;
  assign drainSide.data  = store[rdPtr_r[AW-1:0]];

  // Pointers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end
    else
    begin
      if (push)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (pop)
        rdPtr_r <= rdPtr_r + 1'b1;
    end
  end

  // Storage has no reset; empty guards every read
  always_ff @(posedge clk)
  begin
    if (push)
      store[wrPtr_r[AW-1:0]] <= fillSide.data;
  end
endmodule

// ---- verilog/three_wire_eeprom.sv ----
// Three-wire serial EEPROM: command decoder, array and self-timed programming
`timescale 1ns/1ps
`include "eeprom_map.svh"

// Behaviour
// [R1] Strap high or floating selects 16-bit words, strap low selects 8-bit words.
// [R2] Start 1, opcode 10, 7 or 6 address bits; device returns the word.
// [R3] Enable: opcode 00 with 11 prefix; programming refused until it is run.
// [R4] Erase: opcode 11 plus address; addressed word becomes all ones.
// [R5] Write: opcode 01, address, 8 or 16 data bits; data is stored.
// [R6] Erase-all: opcode 00 with 10 prefix; whole array becomes all ones.
// [R7] Write-all: opcode 00 with 01 prefix, then one word written everywhere.
// [R8] Disable: opcode 00 with 00 prefix; blocks erase and write afterwards.
// [R9] Host clocks every don't-care address position; device counts them.
// [R10] Command starts with select high, then start bit one, opcode, address.
// [R11] Read sends a dummy zero before the data; output moves on clock rise.
// [R12] Programming is disabled at power-up and stays enabled until disabled.
// [R13] Select raised after programming: output low while busy, high when done.
// [R14] Data input sampled on rising serial clock while selected, MSB first.
module three_wire_eeprom
  import eeprom_pkg::*;
#(
  parameter int WP_CYCLES  = `WP_TIME_US * `CLK_FREQ_MHZ,
  parameter int FIFO_DEPTH = `JOB_FIFO_DEPTH
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic chipSelect,
  input  wire logic serialClockIn,
  input  wire logic serialDataIn,
  input  wire logic wordWidthStrap,
  output logic      dataOut,
  output logic      dataOutEn
);
  localparam int JOB_W = $bits(prog_job_s);
  localparam int CNT_W = $clog2(WP_CYCLES + 1);

  if (WP_CYCLES < 1)
  begin : g_wp_chk
    $error("three_wire_eeprom: WP_CYCLES must be at least 1");
  end

  // ================================================================
  // Helpers
  // Word index of an address in either organisation
  function automatic logic [5:0] wordIndex(input logic [6:0] addr, input logic byteMode);
    wordIndex = byteMode ? addr[6:1] : addr[5:0];
  endfunction

  // Lanes touched by a job; byte mode: even address is the low byte
  function automatic logic [15:0] laneMask(input logic byteMode, input logic oddByte, input logic allWords);
    laneMask = (!byteMode || allWords) ? 16'hFFFF : (oddByte ? 16'hFF00 : 16'h00FF);
  endfunction

  // ================================================================
  // Pin synchronisers: every pin is asynchronous to clk
  logic [3:0] syncA_r;
  logic [3:0] syncB_r;
  logic       serClkPrev_r;
  logic       csPrev_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      syncA_r      <= 4'h0;
      syncB_r      <= 4'h0;
      serClkPrev_r <= 1'b0;
      csPrev_r     <= 1'b0;
    end
    else
    begin
      syncA_r      <= {chipSelect, serialClockIn, serialDataIn, wordWidthStrap};
      syncB_r      <= syncA_r;
      serClkPrev_r <= syncB_r[2];
      csPrev_r     <= syncB_r[3];
    end
  end

  wire cs         = syncB_r[3];
  wire dataBit    = syncB_r[1];
  wire byteMode   = !syncB_r[0];                      // [R1]
  wire serClkRise = syncB_r[2] && !serClkPrev_r;
  wire csRise     = cs && !csPrev_r;

  // ================================================================
  // Decoder state and storage
  dec_state_e  state_r;
  logic [4:0]  bitCnt_r;
  logic [7:0]  cmdShift_r;
  logic [15:0] dataShift_r;
  logic [15:0] readShift_r;
  logic [6:0]  jobAddr_r;
  job_kind_e   jobKind_r;
  logic        progEn_r;
  logic        pushPend_r;
  prog_job_s   job_r;
  logic        statusOn_r;
  logic        engActive_r;
  logic [CNT_W-1:0] engCnt_r;
  prog_job_s   engJob_r;
  logic [15:0] mem [`MEM_WORDS];

  stream_if #(.W(JOB_W)) fillBus ();
  stream_if #(.W(JOB_W)) drainBus ();

  // Command field decode; don't-care positions are clocked and counted
  wire [8:0]  frame     = {cmdShift_r, dataBit};    // [R14]
  wire [1:0]  opcode    = byteMode ? frame[8:7] : frame[7:6];
  wire [6:0]  addrField = byteMode ? frame[6:0] : {1'b0, frame[5:0]};
  wire [1:0]  subCode   = byteMode ? frame[6:5] : frame[5:4];
  wire        sampleEn  = cs && serClkRise;
  wire        cmdLast   = sampleEn && state_r == ST_CMD
                          && bitCnt_r == (byteMode ? `CMD_LAST_X8 : `CMD_LAST_X16);   // [R9]
  wire        dataLast  = sampleEn && state_r == ST_DATA
                          && bitCnt_r == (byteMode ? `DATA_LAST_X8 : `DATA_LAST_X16);
  wire        special   = opcode == `OP_SPECIAL;
  wire        isRead    = cmdLast && opcode == `OP_READ;                          // [R2]
  wire        isEnCmd   = cmdLast && special && subCode == `SUB_ENABLE;           // [R3]
  wire        isDisCmd  = cmdLast && special && subCode == `SUB_DISABLE;          // [R8]
  wire        isEraseAl = special && subCode == `SUB_ERASE_ALL;                   // [R6]
  wire        eraseReq  = cmdLast && (opcode == `OP_ERASE || isEraseAl);         // [R4]
  wire        dataStart = cmdLast && (opcode == `OP_WRITE || (special && subCode == `SUB_WRITE_ALL));
  wire        jobSet    = progEn_r && (eraseReq || dataLast);                     // [R3] [R8]
  wire [15:0] data16    = {dataShift_r[14:0], dataBit};
  wire [15:0] rdRaw     = mem[wordIndex(addrField, byteMode)];
  wire [15:0] rdWord    = !byteMode ? rdRaw : (addrField[0] ? {rdRaw[15:8], 8'h00} : {rdRaw[7:0], 8'h00});
  wire        busy      = pushPend_r || drainBus.valid || engActive_r;

  // Serial decoder; a start bit is held off while a job waits for queue space
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r     <= ST_IDLE;
      bitCnt_r    <= 5'h00;
      cmdShift_r  <= 8'h00;
      dataShift_r <= 16'h0000;
      readShift_r <= 16'h0000;
      jobAddr_r   <= 7'h00;
      jobKind_r   <= JOB_WRITE;
    end
    else if (!cs)
      state_r <= ST_IDLE;                             // [R10]
    else if (serClkRise)
    begin
      case (state_r)
        ST_IDLE:
          if (dataBit && !pushPend_r)                 // [R10]
          begin
            state_r    <= ST_CMD;
            bitCnt_r   <= 5'h00;
            cmdShift_r <= 8'h00;
          end
        ST_CMD:
        begin
          cmdShift_r <= frame[7:0];                   // [R14]
          bitCnt_r   <= bitCnt_r + 5'h01;
          if (cmdLast)
          begin
            bitCnt_r    <= 5'h00;
            jobAddr_r   <= addrField;
            jobKind_r   <= (opcode == `OP_WRITE) ? JOB_WRITE : JOB_WRITE_ALL;     // [R5] [R7]
            readShift_r <= rdWord;                    // [R2]
            state_r     <= isRead ? ST_READOUT : (dataStart ? ST_DATA : ST_DONE);
          end
        end
        ST_DATA:
        begin
          dataShift_r <= data16;
          bitCnt_r    <= bitCnt_r + 5'h01;
          if (dataLast)
            state_r <= ST_DONE;
        end
        ST_READOUT:
          readShift_r <= {readShift_r[14:0], 1'b0};
        ST_DONE:
          state_r <= ST_DONE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Enable flag; power-up leaves programming disabled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      progEn_r <= 1'b0;                               // [R12]
    else if (isEnCmd)
      progEn_r <= 1'b1;                               // [R3]
    else if (isDisCmd)
      progEn_r <= 1'b0;                               // [R8]
  end

  // ================================================================
  // Job hand-off into the queue; full queue stalls the decoder
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pushPend_r <= 1'b0;
      job_r      <= '0;
    end
    else if (jobSet)
    begin
      pushPend_r    <= 1'b1;
      job_r.kind    <= dataLast ? jobKind_r : (isEraseAl ? JOB_ERASE_ALL : JOB_ERASE);
      job_r.addr    <= dataLast ? jobAddr_r : addrField;
      job_r.data    <= dataLast ? data16 : `ERASED_WORD;                         // [R4] [R6]
      job_r.byteMode <= byteMode;
    end
    else if (fillBus.ready)
      pushPend_r <= 1'b0;
  end

  assign fillBus.valid  = pushPend_r;
  assign fillBus.data   = job_r;
  assign drainBus.ready = !engActive_r;

  job_fifo #(
    .WIDTH (JOB_W),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .clk       (clk),
    .rst       (rst),
    .fillSide  (fillBus),
    .drainSide (drainBus)
  );

  // ================================================================
  // Self-timed programming engine; array changes at the end of the cycle
  wire        applyEn  = engActive_r && engCnt_r == '0;
  wire        allWords = engJob_r.kind == JOB_ERASE_ALL || engJob_r.kind == JOB_WRITE_ALL;
  wire [15:0] effData  = engJob_r.byteMode ? {2{engJob_r.data[7:0]}} : engJob_r.data;
  wire [15:0] mask     = laneMask(engJob_r.byteMode, engJob_r.addr[0], allWords);
  wire [5:0]  engIdx   = wordIndex(engJob_r.addr, engJob_r.byteMode);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      engActive_r <= 1'b0;
      engCnt_r    <= '0;
      engJob_r    <= '0;
    end
    else if (drainBus.valid && !engActive_r)
    begin
      engActive_r <= 1'b1;
      engCnt_r    <= CNT_W'(WP_CYCLES - 1);
      engJob_r    <= drainBus.data;
    end
    else if (applyEn)
      engActive_r <= 1'b0;
    else if (engActive_r)
      engCnt_r <= engCnt_r - 1'b1;
  end

  // Array words; reset to erased since flip-flops lose content
  for (genvar i = 0; i < `MEM_WORDS; i++)
  begin : g_mem
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        mem[i] <= `ERASED_WORD;
      else if (applyEn && (allWords || engIdx == 6'(i)))                     // [R6] [R7]
        mem[i] <= (mem[i] & ~mask) | (effData & mask);                       // [R4] [R5]
    end
  end

  // ================================================================
  // Output pin: ready/busy status after select rises, or read data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      statusOn_r <= 1'b0;
      dataOut    <= 1'b0;
      dataOutEn  <= 1'b0;
    end
    else
    begin
      statusOn_r <= cs && (csRise ? busy : (statusOn_r && !(serClkRise && dataBit)));   // [R13]
      dataOutEn  <= cs && (statusOn_r || state_r == ST_READOUT);
      if (statusOn_r)
        dataOut <= !busy;                             // [R13]
      else if (isRead)
        dataOut <= 1'b0;                              // [R11]
      else if (sampleEn && state_r == ST_READOUT)
        dataOut <= readShift_r[15];                   // [R11]
    end
  end

  // ================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Word picked by a plain x16 index, kept apart from the decoder's own lookup
  wire [15:0] chkWord = mem[addrField[5:0]];

  AST_ENABLE_ONLY_BY_CMD: assert property (progEn_r && !$past(progEn_r) |-> $past(isEnCmd)) // [R3]
    else $error("programming enabled without enable command");
  AST_DISABLE_CLEARS: assert property (isDisCmd && !isEnCmd |=> !progEn_r ##1 !jobSet || progEn_r) // [R8]
    else $error("disable command did not block programming");
  AST_NO_JOB_WHEN_OFF: assert property ($rose(pushPend_r) |-> $past(progEn_r)) // [R12]
    else $error("programming job raised while disabled");
  AST_DUMMY_ZERO: assert property (isRead |=> !dataOut && state_r == ST_READOUT) // [R11]
    else $error("read did not start with dummy zero");
  AST_READ_WORD: assert property (isRead && !byteMode && !busy |=> readShift_r == $past(chkWord)) // [R2]
    else $error("read word does not match array");
  AST_OE_OFF_UNSELECTED: assert property (!cs |=> !dataOutEn) // [R10]
    else $error("output driven while deselected");
  AST_ERASE_ONES: assert property (applyEn && engJob_r.kind == JOB_ERASE && !engJob_r.byteMode
                                   |=> mem[$past(engIdx)] == `ERASED_WORD) // [R4]
    else $error("erase left zero bits");
  AST_WRITE_STORES: assert property (applyEn && engJob_r.kind == JOB_WRITE && !engJob_r.byteMode
                                     |=> mem[$past(engIdx)] == $past(engJob_r.data)) // [R5]
    else $error("write data not stored");
  AST_STATUS_BUSY: assert property (statusOn_r && busy && cs && !serClkRise |=> !dataOut ##1 dataOutEn || !cs) // [R13]
    else $error("status not low while busy");
endmodule

// ---- tb/host_model.sv ----
// Host controller model that drives the three-wire serial link
`timescale 1ns/1ps
module host_model (
  input  wire logic clk,
  input  wire logic dataPin,
  output logic      chipSelect,
  output logic      serialClockIn,
  output logic      serialDataIn
);
  // Half of the 160 ns serial clock, in 10 ns system cycles
  localparam int HALF = 8;

  // Serial clock stands low and the select is off outside frames
  initial
  begin
    chipSelect    = 1'b0;
    serialClockIn = 1'b0;
    serialDataIn  = 1'b0;
  end

  // ================================================================
  // One frame: select, then every bit clocked MSB first, don't-care bits too
  task automatic frame(input logic [31:0] bits, input int n, output logic [31:0] got);
    got = '0;
    @(negedge clk);
    chipSelect = 1'b1;
    repeat (2) @(negedge clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      serialDataIn = bits[i];
      repeat (HALF) @(negedge clk);
      got = {got[30:0], dataPin};  // Output has settled since the previous rise
      serialClockIn = 1'b1;
      repeat (HALF) @(negedge clk);
      serialClockIn = 1'b0;
    end
    repeat (2) @(negedge clk);
    chipSelect   = 1'b0;
    serialDataIn = ~serialDataIn;  // A stale level must not pass for held data
    repeat (HALF) @(negedge clk);
  endtask

  // ================================================================
  // Raise select after a programming frame and poll the ready level
  task automatic status(output logic busyAtStart, output logic readySeen);
    readySeen = 1'b0;
    @(negedge clk);
    chipSelect = 1'b1;
    repeat (HALF) @(negedge clk);
    busyAtStart = dataPin;
    for (int i = 0; i < 70000 && readySeen !== 1'b1; i++)
    begin
      @(negedge clk);
      readySeen = (dataPin === 1'b1);
    end
    chipSelect = 1'b0;
    repeat (HALF) @(negedge clk);
  endtask
endmodule

// ---- tb/test_three_wire_eeprom_command_decoder.sv ----
// Self-checking testbench of the three-wire EEPROM decoder
`timescale 1ns/1ps
`include "eeprom_map.svh"
module test_three_wire_eeprom_command_decoder;
  // Short programming time keeps the queue test within the run budget
  localparam int WP = 5500;

  logic clk;
  logic rst;
  logic strap;
  logic chipSelect;
  logic serialClockIn;
  logic serialDataIn;
  logic dataOut;
  logic dataOutEn;
  wire  dataPin;
  int   badCount = 0;
  int   numChecks = 0;

  // Released pin floats, so a missing enable never reads as a valid bit
  assign dataPin = dataOutEn ? dataOut : 1'bz;

  three_wire_eeprom #(.WP_CYCLES(WP), .FIFO_DEPTH(8)) DUT (
    .clk            (clk),
    .rst            (rst),
    .chipSelect     (chipSelect),
    .serialClockIn  (serialClockIn),
    .serialDataIn   (serialDataIn),
    .wordWidthStrap (strap),
    .dataOut        (dataOut),
    .dataOutEn      (dataOutEn)
  );

  host_model host (
    .clk           (clk),
    .dataPin       (dataPin),
    .chipSelect    (chipSelect),
    .serialClockIn (serialClockIn),
    .serialDataIn  (serialDataIn)
  );

  // ================================================================
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #1_100_000;
    badCount++;
    testDone();
  end

  // ================================================================
  // Shared helpers
  task automatic testDone;
    $display("checks %0d, mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Builds start bit, opcode, address and data tail, then sends one frame
  task automatic cmd(input logic [1:0] op, input logic [6:0] addr, input logic [15:0] data,
                     input int dataBits, output logic [31:0] got);
    int          alen;
    logic [31:0] bits;
    alen = strap ? 6 : 7;
    bits = {29'h0, 1'b1, op};
    bits = (bits << alen) | (32'(addr) & ((32'h1 << alen) - 32'h1));
    bits = (bits << dataBits) | 32'(data);
    host.frame(bits, 3 + alen + dataBits, got);
  endtask

  // Programming frame; with job set, the busy then ready status is judged
  task automatic send(input logic [1:0] op, input logic [6:0] addr, input logic [15:0] data,
                      input int dataBits, input bit job);
    logic [31:0] got;
    logic        busy;
    logic        ready;
    cmd(op, addr, data, dataBits, got);
    if (job)
    begin
      host.status(busy, ready);
      check("status busy", 32'h0, {31'h0, busy});
      check("status ready", 32'h1, {31'h0, ready});
    end
  endtask

  // Special opcode carries its sub-command in the two leading address bits
  function automatic logic [6:0] spAddr(input logic [1:0] sub);
    return strap ? {1'b0, sub, 4'h0} : {sub, 5'h00};
  endfunction

  // Read: one dummy zero, then the word MSB first
  task automatic rd(input logic [6:0] addr, input logic [15:0] exp);
    logic [31:0] got;
    cmd(`OP_READ, addr, 16'h0000, strap ? 17 : 9, got);
    if (strap)
      check("read x16", {16'h0000, exp}, got & 32'h0001_FFFF);
    else
      check("read x8", {24'h00_0000, exp[7:0]}, got & 32'h0000_01FF);
  endtask

  // ================================================================
  // Scenarios
  task automatic powerUpLocked;
    logic [31:0] got;
    cmd(`OP_WRITE, 7'h03, 16'h1234, 16, got);
    rd(7'h03, `ERASED_WORD);
  endtask

  // Eleven writes back to back fill the job queue until the eleventh frame is dropped
  task automatic queueFill;
    logic [31:0] got;
    logic        busy;
    logic        ready;
    send(`OP_SPECIAL, spAddr(`SUB_ENABLE), 16'h0000, 0, 1'b0);
    for (int i = 0; i < 11; i++)
      cmd(`OP_WRITE, 7'(i), 16'hA000 + 16'(i), 16, got);
    host.status(busy, ready);
    check("queue busy", 32'h0, {31'h0, busy});
    check("queue ready", 32'h1, {31'h0, ready});
    for (int i = 0; i < 8; i++)
      rd(7'(i), 16'hA000 + 16'(i));
    rd(7'h0A, `ERASED_WORD);
  endtask

  task automatic eraseOne;
    send(`OP_ERASE, 7'h02, 16'h0000, 0, 1'b1);
    rd(7'h02, `ERASED_WORD);
    rd(7'h01, 16'hA001);
  endtask

  task automatic fillAndWipe;
    send(`OP_SPECIAL, spAddr(`SUB_WRITE_ALL), 16'h5A5A, 16, 1'b1);
    rd(7'h00, 16'h5A5A);
    rd(7'h3F, 16'h5A5A);
    send(`OP_SPECIAL, spAddr(`SUB_ERASE_ALL), 16'h0000, 0, 1'b1);
    rd(7'h05, `ERASED_WORD);
  endtask

  // Byte organisation: byte 7 is the high half of word 3
  task automatic byteMode;
    strap = 1'b0;
    repeat (4) @(negedge clk);
    send(`OP_WRITE, 7'h07, 16'h003C, 8, 1'b1);
    rd(7'h07, 16'h003C);
    rd(7'h06, 16'h00FF);
    strap = 1'b1;
    repeat (4) @(negedge clk);
    rd(7'h03, 16'h3CFF);
  endtask

  task automatic lockedAgain;
    send(`OP_SPECIAL, spAddr(`SUB_DISABLE), 16'h0000, 0, 1'b0);
    send(`OP_WRITE, 7'h09, 16'h1234, 16, 1'b0);
    send(`OP_ERASE, 7'h03, 16'h0000, 0, 1'b0);
    rd(7'h09, `ERASED_WORD);
    rd(7'h03, 16'h3CFF);
  endtask

  // ================================================================
  // Main sequence
  initial
  begin
    rst   = 1'b1;
    strap = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    powerUpLocked();
    queueFill();
    eraseOne();
    fillAndWipe();
    byteMode();
    lockedAgain();
    testDone();
  end
endmodule
